/* File: core/ctal_pkg.sv */
// package: constants, register map and types of the case tamper alert logic
package ctal_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int RTC_PERIOD_NS = 30518;
   localparam int RTC_CYCLES = RTC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DEB_SAMPLES = 2;
   localparam int CLR_LATENCY_TICKS = 2;
   localparam int SWITCH_MIN_US = 1000;
   localparam int ENVELOPE_WORDS = 256;
   localparam int CONFIG_WORDS = 64;
   localparam int AXI_ADDR_W = 8;
   localparam int TIMER_W = 16;

   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_WDOG_RELOAD = 8'h0C;
   localparam logic [7:0] OFS_WDOG_KICK = 8'h10;
   localparam logic [7:0] OFS_HB_PERIOD = 8'h14;
   localparam logic [7:0] OFS_SYS_ID = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;

   localparam int ST_CASE = 0;
   localparam int ST_THERM = 1;
   localparam int ST_WDOG = 2;
   localparam int ST_HB = 3;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_WD_EN = 2;
   localparam int CTRL_HB_EN = 3;
   localparam int CTRL_SLEEP = 4;
   localparam int STATE_PEND_LSB = 4;

   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [15:0] RST_WDOG_RELOAD = 16'h0400;
   localparam logic [15:0] RST_HB_PERIOD = 16'h8000;
   // identity value is arbitrary
   localparam logic [15:0] RST_SYS_ID = 16'h0A5C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEL_NONE, SEL_IRQ, SEL_MGMT} ctal_sel_t;
   typedef enum logic [1:0] {
      ALERT_CASE, ALERT_THERM, ALERT_WDOG, ALERT_HB
   } ctal_kind_t;
   typedef struct packed {
      logic heartbeat;
      logic watchdog;
      logic thermal;
      logic case_open;
   } ctal_evt_t;
   typedef struct packed {
      ctal_kind_t kind;
      ctal_evt_t health;
      logic [15:0] sys_id;
   } ctal_alert_t;
endpackage : ctal_pkg

/* File: core/ctal_debounce.sv */
// two-flop synchroniser and slow-tick debouncer for an active-low pin
`timescale 1ns/10ps
module ctal_debounce
   import ctal_pkg::*;
#(
   parameter int SAMPLES = DEB_SAMPLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_n,
   input wire logic tick,
   output logic level
);
   logic sync1_reg;
   logic sync2_reg;
   logic [SAMPLES-2:0] hist_reg;
   logic level_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= ~pin_n;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hist_reg <= '0;
         level_reg <= 1'b0;
      end else if (tick) begin
         hist_reg <= (SAMPLES-1)'({hist_reg, sync2_reg});
         level_reg <= &{hist_reg, sync2_reg};
      end
   end

   assign level = level_reg;

   a_deb_two_samples: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(level_reg) |-> $past(tick) && $past(sync2_reg)
         && $past(hist_reg[0]))
      else $error("debounce asserted without two high samples");
   a_deb_tick_only: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(tick) |-> $stable(level_reg))
      else $error("debounce level moved off a slow tick");
endmodule : ctal_debounce

/* File: core/ctal_timer.sv */
// reloadable down-counter on the slow tick, one-cycle expiry pulse
`timescale 1ns/10ps
module ctal_timer #(
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic restart,
   input wire logic [W-1:0] period,
   output logic expire
);
   logic [W-1:0] cnt_reg;
   logic expire_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
         expire_reg <= 1'b0;
      end else begin
         expire_reg <= 1'b0;
         if (!enable || restart) begin
            cnt_reg <= period;
         end else if (tick) begin
            if (cnt_reg == '0) begin
               expire_reg <= 1'b1;
               cnt_reg <= period;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end

   assign expire = expire_reg;
endmodule : ctal_timer

/* File: core/ctal_core.sv */
// case tamper alert logic: AXI4-Lite registers, intrusion flag, alerts
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module ctal_core
   import ctal_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic case_open_n,
   input wire logic overheat_input_n,
   output logic mgmt_interrupt_out,
   output logic irq,
   output logic sleep_entry_out,
   output logic alert_valid,
   input wire logic alert_ready,
   output ctal_alert_t alert_data
);
   function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] a);
      unique case (a)
         OFS_STATUS, OFS_MASK, OFS_CTRL, OFS_WDOG_RELOAD,
         OFS_WDOG_KICK, OFS_HB_PERIOD, OFS_SYS_ID, OFS_STATE: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   endfunction : addr_ok

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   function automatic ctal_kind_t first_kind(input logic [3:0] p);
      first_kind = ALERT_HB;
      for (int i = 3; i >= 0; i--) begin
         if (p[i]) begin
            first_kind = ctal_kind_t'(i[1:0]);
         end
      end
   endfunction : first_kind

   // slow real-time tick
   logic [11:0] rtc_cnt_reg;
   logic rtc_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rtc_cnt_reg <= '0;
      end else if (rtc_cnt_reg == 12'(RTC_CYCLES - 1)) begin
         rtc_cnt_reg <= '0;
      end else begin
         rtc_cnt_reg <= rtc_cnt_reg + 12'h001;
      end
   end
   assign rtc_tick = (rtc_cnt_reg == 12'(RTC_CYCLES - 1));

   // AXI4-Lite slave
   logic aw_full_reg;
   logic w_full_reg;
   logic [AXI_ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_word;
   logic wr_fire;
   logic [31:0] wd;

   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wd = merge(32'h0000_0000, wdata_reg, wstrb_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         awaddr_reg <= '0;
      end else if (s_axi_awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (s_axi_wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= rd_word;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   logic wr_status;
   logic wr_kick;
   logic wr_period;
   assign wr_status = wr_fire && awaddr_reg == OFS_STATUS;
   assign wr_kick = wr_fire && awaddr_reg == OFS_WDOG_KICK;
   assign wr_period = wr_fire && awaddr_reg == OFS_HB_PERIOD;

   // software-written configuration
   logic [3:0] mask_reg;
   ctal_sel_t sel_reg;
   logic wd_en_reg;
   logic hb_en_reg;
   logic sleep_reg;
   logic [TIMER_W-1:0] reload_reg;
   logic [TIMER_W-1:0] period_reg;
   logic [15:0] sys_id_reg;
   logic [31:0] ctrl_new;

   assign ctrl_new = merge({27'h0, sleep_reg, hb_en_reg, wd_en_reg, sel_reg},
      wdata_reg, wstrb_reg);

   // byte-merged next values; a call result cannot be part-selected
   logic [31:0] mask_new;
   logic [31:0] reload_new;
   logic [31:0] period_new;
   logic [31:0] id_new;
   assign mask_new = merge({28'h0, mask_reg}, wdata_reg, wstrb_reg);
   assign reload_new = merge({16'h0, reload_reg}, wdata_reg, wstrb_reg);
   assign period_new = merge({16'h0, period_reg}, wdata_reg, wstrb_reg);
   assign id_new = merge({16'h0, sys_id_reg}, wdata_reg, wstrb_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_reg <= RST_MASK;
         sel_reg <= SEL_NONE;
         wd_en_reg <= 1'b0;
         hb_en_reg <= 1'b0;
         reload_reg <= RST_WDOG_RELOAD;
         period_reg <= RST_HB_PERIOD;
         sys_id_reg <= RST_SYS_ID;
      end else if (wr_fire) begin
         unique case (awaddr_reg)
            OFS_MASK: mask_reg <= mask_new[3:0];
            OFS_CTRL: begin
               // unused select code reads as no action
               sel_reg <= (ctrl_new[CTRL_SEL_LSB +: 2] == 2'h3) ? SEL_NONE :
                  ctal_sel_t'(ctrl_new[CTRL_SEL_LSB +: 2]);
               wd_en_reg <= ctrl_new[CTRL_WD_EN];
               hb_en_reg <= ctrl_new[CTRL_HB_EN];
            end
            OFS_WDOG_RELOAD: reload_reg <= reload_new[TIMER_W-1:0];
            OFS_HB_PERIOD: period_reg <= period_new[TIMER_W-1:0];
            OFS_SYS_ID: sys_id_reg <= id_new[15:0];
            default: ;
         endcase
      end
   end

   // sleep request pulses for one cycle per write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_reg <= 1'b0;
      end else begin
         sleep_reg <= wr_fire && awaddr_reg == OFS_CTRL
            && wd[CTRL_SLEEP];
      end
   end
   assign sleep_entry_out = sleep_reg;

   // input conditioning
   logic case_deb;
   logic therm_deb;

   ctal_debounce #(.SAMPLES(DEB_SAMPLES)) u_case_deb (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_n(case_open_n),
      .tick(rtc_tick),
      .level(case_deb)
   );

   ctal_debounce #(.SAMPLES(DEB_SAMPLES)) u_therm_deb (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_n(overheat_input_n),
      .tick(rtc_tick),
      .level(therm_deb)
   );

   // intrusion flag lives in the slow-tick domain
   logic case_flag_reg;
   logic clr_pend_reg;
   logic case_prev_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         case_flag_reg <= 1'b0;
         clr_pend_reg <= 1'b0;
      end else begin
         if (rtc_tick) begin
            if (case_deb) begin
               case_flag_reg <= 1'b1;
            end else if (clr_pend_reg) begin
               case_flag_reg <= 1'b0;
            end
            clr_pend_reg <= 1'b0;
         end
         if (wr_status && wd[ST_CASE]) begin
            clr_pend_reg <= 1'b1;
         end
      end
   end

   // other event flags: a set wins over a clear in the same cycle
   logic therm_prev_reg;
   logic therm_set;
   logic therm_flag_reg;
   logic wdog_flag_reg;
   logic hb_flag_reg;
   logic wd_expire;
   logic hb_expire;

   assign therm_set = therm_deb && !therm_prev_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         therm_prev_reg <= 1'b0;
         case_prev_reg <= 1'b0;
         therm_flag_reg <= 1'b0;
         wdog_flag_reg <= 1'b0;
         hb_flag_reg <= 1'b0;
      end else begin
         therm_prev_reg <= therm_deb;
         case_prev_reg <= case_flag_reg;
         therm_flag_reg <= therm_set ||
            (therm_flag_reg && !(wr_status && wd[ST_THERM]));
         wdog_flag_reg <= wd_expire ||
            (wdog_flag_reg && !(wr_status && wd[ST_WDOG]));
         hb_flag_reg <= hb_expire ||
            (hb_flag_reg && !(wr_status && wd[ST_HB]));
      end
   end

   ctal_timer #(.W(TIMER_W)) u_wdog (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(rtc_tick),
      .enable(wd_en_reg),
      .restart(wr_kick),
      .period(reload_reg),
      .expire(wd_expire)
   );

   ctal_timer #(.W(TIMER_W)) u_hb (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(rtc_tick),
      .enable(hb_en_reg),
      .restart(wr_period),
      .period(period_reg),
      .expire(hb_expire)
   );

   ctal_evt_t status;
   ctal_evt_t irq_src;
   assign status = '{hb_flag_reg, wdog_flag_reg, therm_flag_reg,
      case_flag_reg};
   assign irq_src = '{hb_flag_reg, wdog_flag_reg, therm_flag_reg,
      case_flag_reg && sel_reg == SEL_IRQ};
   assign irq = |(irq_src & mask_reg);
   assign mgmt_interrupt_out = case_flag_reg
      && sel_reg == SEL_MGMT;

   // network alert requests, lowest-numbered kind first by priority
   logic [3:0] pend_reg;
   logic [3:0] new_evt;
   logic [3:0] take;
   logic alert_valid_reg;
   ctal_alert_t alert_reg;

   assign new_evt = {hb_expire, wd_expire, therm_set,
      case_flag_reg && !case_prev_reg};
   assign take = (!alert_valid_reg) ? (pend_reg & (~pend_reg + 4'h1)) : 4'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_reg <= 4'h0;
      end else begin
         pend_reg <= (pend_reg & ~take) | new_evt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alert_valid_reg <= 1'b0;
         alert_reg <= '0;
      end else if (alert_valid_reg && alert_ready) begin
         alert_valid_reg <= 1'b0;
      end else if (!alert_valid_reg && |pend_reg) begin
         alert_valid_reg <= 1'b1;
         alert_reg <= '{first_kind(pend_reg), status, sys_id_reg};
      end
   end
   assign alert_valid = alert_valid_reg;
   assign alert_data = alert_reg;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         OFS_STATUS: rd_word = {28'h0, status};
         OFS_MASK: rd_word = {28'h0, mask_reg};
         OFS_CTRL: rd_word = {28'h0, hb_en_reg, wd_en_reg, sel_reg};
         OFS_WDOG_RELOAD: rd_word = {16'h0, reload_reg};
         OFS_HB_PERIOD: rd_word = {16'h0, period_reg};
         OFS_SYS_ID: rd_word = {16'h0, sys_id_reg};
         OFS_STATE: rd_word = {24'h0, pend_reg, 1'b0, alert_valid_reg,
            therm_deb, case_deb};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // clear latency watch
   logic [12:0] clr_age_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn || !clr_pend_reg) begin
         clr_age_reg <= '0;
      end else begin
         clr_age_reg <= clr_age_reg + 13'h0001;
      end
   end

   a_flag_tick_only: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(case_flag_reg) |-> $past(rtc_tick))
      else $error("case flag changed off a slow tick");
   a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      rtc_tick && case_deb |=> case_flag_reg)
      else $error("debounced case-open did not set flag");
   a_clear_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      case_flag_reg && clr_pend_reg && case_deb && rtc_tick
      |=> case_flag_reg && mgmt_interrupt_out == (sel_reg == SEL_MGMT))
      else $error("flag cleared while switch active");
   a_clear_latency: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_age_reg <= 13'(CLR_LATENCY_TICKS * RTC_CYCLES))
      else $error("clear pending longer than two slow ticks");
   a_w1c_request: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_status && wd[ST_CASE] |=> clr_pend_reg)
      else $error("status write did not request a clear");
   a_sel_forces_off: assert property (@(posedge aclk) disable iff (!aresetn)
      sel_reg != SEL_MGMT |-> !mgmt_interrupt_out)
      else $error("management interrupt without select");
   a_irq_route: assert property (@(posedge aclk) disable iff (!aresetn)
      case_flag_reg && sel_reg == SEL_IRQ && mask_reg[ST_CASE] |-> irq)
      else $error("ordinary interrupt missing");
   a_thermal_event: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(therm_deb) |=> therm_flag_reg && $past(new_evt[ST_THERM]))
      else $error("thermal event not registered");
   a_wdog_alert: assert property (@(posedge aclk) disable iff (!aresetn)
      wd_expire |=> wdog_flag_reg && (pend_reg[ST_WDOG]
      || alert_reg.kind == ALERT_WDOG))
      else $error("watchdog expiry raised no alert");
   a_hb_alert: assert property (@(posedge aclk) disable iff (!aresetn)
      hb_expire |=> ##[0:8] alert_valid_reg)
      else $error("heartbeat raised no alert");

   c_flag_set: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(case_flag_reg));
   c_mgmt: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(mgmt_interrupt_out));
   c_refused: cover property (@(posedge aclk) disable iff (!aresetn)
      clr_pend_reg && case_deb && rtc_tick);
   c_alert: cover property (@(posedge aclk) disable iff (!aresetn)
      alert_valid_reg && alert_ready);
endmodule : ctal_core

/* File: test/ctal_far_side.sv */
// far-side model: case switch, thermal sensor and alert sink
`timescale 1ns/10ps
module ctal_far_side
   import ctal_pkg::*;
(
   input wire logic aclk,
   input wire logic open_cmd,
   input wire logic heat_cmd,
   input wire logic stall,
   input wire logic alert_valid,
   input wire ctal_alert_t alert_data,
   output logic case_open_n,
   output logic overheat_input_n,
   output logic alert_ready,
   output logic [3:0] seen,
   output logic [15:0] last_id
);
   // alert envelope store kept by the platform, one slot per kind
   logic [15:0] envelope [ENVELOPE_WORDS];
   // closed contacts pull the active-low pins down
   assign case_open_n = !open_cmd;
   assign overheat_input_n = !heat_cmd;
   initial begin
      alert_ready = 1'b0;
      seen = 4'h0;
      last_id = 16'h0000;
   end
   // sink may stall; an alert counts only when taken
   always @(posedge aclk) begin
      alert_ready <= !stall;
      if (alert_valid && alert_ready) begin
         seen[alert_data.kind] <= 1'b1;
         last_id <= alert_data.sys_id;
         envelope[alert_data.kind] <= alert_data.sys_id;
      end
   end
endmodule : ctal_far_side

/* File: test/ctal_core_tb_top.sv */
// testbench: register sequences against the case tamper alert logic
`timescale 1ns/10ps
module ctal_core_tb_top
   import ctal_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic open = 1'b0;
   logic heat = 1'b0;
   logic stall = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic case_n, heat_n, mgmt, irq, sleep, a_valid, a_ready;
   ctal_alert_t a_data;
   logic [3:0] seen;
   logic [15:0] last_id;
   int fail_count = 0;
   int comparisons = 0;
   int sleeps = 0;
   time t0;
   logic [7:0] ofs [6] = '{OFS_STATUS, OFS_MASK, OFS_CTRL,
      OFS_WDOG_RELOAD, OFS_HB_PERIOD, OFS_SYS_ID};
   logic [31:0] rst [6] = '{32'h0, 32'h0, 32'h0, {16'h0, RST_WDOG_RELOAD},
      {16'h0, RST_HB_PERIOD}, {16'h0, RST_SYS_ID}};

   ctal_core dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .case_open_n(case_n), .overheat_input_n(heat_n),
      .mgmt_interrupt_out(mgmt), .irq(irq), .sleep_entry_out(sleep),
      .alert_valid(a_valid), .alert_ready(a_ready), .alert_data(a_data));
   ctal_far_side far (.aclk(aclk), .open_cmd(open), .heat_cmd(heat),
      .stall(stall), .alert_valid(a_valid), .alert_data(a_data),
      .case_open_n(case_n), .overheat_input_n(heat_n),
      .alert_ready(a_ready), .seen(seen), .last_id(last_id));

   initial begin
      forever #10 aclk = !aclk;
   end
   always @(posedge aclk) begin
      if (sleep === 1'b1) sleeps++;
   end

   task automatic close_out();
      if (fail_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // pins are looked at once the edge's updates have landed
   task automatic pin(input logic got, input logic exp);
      #1;
      chk({31'h0, got}, {31'h0, exp});
   endtask : pin

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rdc

   task automatic ticks(input int n);
      repeat (n * RTC_CYCLES) @(posedge aclk);
   endtask : ticks

   initial begin
      #1800000;
      fail_count++;
      close_out();
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         rdc(ofs[i], 32'hFFFFFFFF, rst[i], RESP_OKAY);
      end
      rdc(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'h1, RESP_SLVERR);
      wr(OFS_MASK, 32'h1, RESP_OKAY);
      wr(OFS_CTRL, {30'h0, SEL_MGMT}, RESP_OKAY);
      t0 = $time;
      open <= 1'b1;
      repeat (1400) @(posedge aclk);
      rdc(OFS_STATUS, 32'h1, 32'h0, RESP_OKAY);
      ticks(3);
      rdc(OFS_STATUS, 32'h1, 32'h1, RESP_OKAY);
      pin(mgmt, 1'b1);
      pin(irq, 1'b0);
      wr(OFS_STATUS, 32'h1, RESP_OKAY);
      ticks(3);
      rdc(OFS_STATUS, 32'h1, 32'h1, RESP_OKAY);
      pin(mgmt, 1'b1);
      wr(OFS_CTRL, {30'h0, SEL_IRQ}, RESP_OKAY);
      pin(mgmt, 1'b0);
      pin(irq, 1'b1);
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      pin(mgmt, 1'b0);
      pin(irq, 1'b0);
      while ($time - t0 < SWITCH_MIN_US * 1000) @(posedge aclk);
      open <= 1'b0;
      ticks(2);
      wr(OFS_STATUS, 32'h1, RESP_OKAY);
      ticks(3);
      rdc(OFS_STATUS, 32'h1, 32'h0, RESP_OKAY);
      rdc(OFS_STATE, 32'h1, 32'h0, RESP_OKAY);
      open <= 1'b1;
      ticks(4);
      rdc(OFS_STATUS, 32'h1, 32'h1, RESP_OKAY);
      pin(mgmt, 1'b0);
      open <= 1'b0;
      stall <= 1'b1;
      wr(OFS_WDOG_RELOAD, 32'h2, RESP_OKAY);
      wr(OFS_HB_PERIOD, 32'h3, RESP_OKAY);
      heat <= 1'b1;
      wr(OFS_CTRL, 32'h0C, RESP_OKAY);
      ticks(5);
      rdc(OFS_STATUS, 32'hE, 32'hE, RESP_OKAY);
      rdc(OFS_STATE, 32'h4, 32'h4, RESP_OKAY);
      chk({16'h0, a_data.sys_id}, {16'h0, RST_SYS_ID});
      wr(OFS_MASK, 32'h2, RESP_OKAY);
      pin(irq, 1'b1);
      wr(OFS_MASK, 32'h0, RESP_OKAY);
      pin(irq, 1'b0);
      stall <= 1'b0;
      heat <= 1'b0;
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      repeat (20) @(posedge aclk);
      chk({28'h0, seen}, 32'hF);
      chk({16'h0, last_id}, {16'h0, RST_SYS_ID});
      chk({16'h0, far.envelope[3]}, {16'h0, RST_SYS_ID});
      wr(OFS_CTRL, 32'h10, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(sleeps, 32'h1);
      close_out();
   end
endmodule : ctal_core_tb_top
